// ==== verilog/lcdc_pkg.sv ====
`default_nettype none
package lcdc_pkg;
	localparam int BYTE_W     = 8;
	localparam int NIB_W      = 4;
	localparam int ADDR_W     = 6;
	localparam int BANK_WORDS = 50;
	localparam int NUM_COLS   = 50;
	localparam int COLS_16S   = 42;
	localparam int NUM_ROWS   = 16;
	localparam int CHAR_COLS  = 5;
	localparam int CHAR_ROWS  = 7;
	localparam int CHAR_CODES = 160;
	localparam int CG_BITS    = CHAR_COLS * CHAR_ROWS;
	localparam int CURSOR_BIT = 7;

	localparam logic [ADDR_W-1:0] ADDR_LAST  = 6'h31;
	localparam logic [ADDR_W-1:0] STEP_PLUS1 = 6'h01;
	localparam logic [ADDR_W-1:0] STEP_MIN1  = 6'h3F;
	localparam logic [ADDR_W-1:0] STEP_PLUS5 = 6'h05;
	localparam logic [ADDR_W-1:0] STEP_MIN5  = 6'h3B;
	localparam logic [2:0]        CHAR_LAST  = 3'h4;

	localparam logic [7:0] CG_SET1_LO = 8'h20;
	localparam logic [7:0] CG_SET1_HI = 8'h7F;
	localparam logic [7:0] CG_SET2_LO = 8'hA0;
	localparam logic [7:0] CG_SET2_HI = 8'hDF;
	localparam logic [7:0] CG_SET2_AT = 8'h60;

	// data processing modes
	localparam logic [2:0] MODE_WRITE  = 3'h0;
	localparam logic [2:0] MODE_AND    = 3'h1;
	localparam logic [2:0] MODE_OR     = 3'h2;
	localparam logic [2:0] MODE_READ   = 3'h3;
	localparam logic [2:0] MODE_CHAR_A = 3'h4;
	localparam logic [2:0] MODE_CHAR_B = 3'h5;
	// pointer directions
	localparam logic [1:0] DIR_HOLD = 2'h0;
	localparam logic [1:0] DIR_UP   = 2'h1;
	localparam logic [1:0] DIR_DOWN = 2'h2;

	localparam logic [2:0] LAYOUT_16_SINGLE = 3'h7;
	localparam logic [2:0] LAYOUT_16_HIGH   = 3'h4;

	localparam logic [2:0] SER_LAST = 3'h7;
	localparam logic [2:0] PAR_LAST = 3'h1;

	// positions in the synchronised input vector
	localparam int IN_CS   = 0;
	localparam int IN_STB  = 1;
	localparam int IN_CD   = 2;
	localparam int IN_SYNC = 3;
	localparam int IN_D    = 4;
	localparam int IN_W    = 8;

	// values after reset
	localparam logic [2:0]        MODE_RST   = MODE_WRITE;
	localparam logic [1:0]        DIR_RST    = DIR_HOLD;
	localparam logic [ADDR_W-1:0] PTR_RST    = 6'h00;
	localparam logic [2:0]        LAYOUT_RST = 3'h0;
	localparam logic [3:0]        FFREQ_RST  = 4'h0;

	typedef struct packed {
		logic             cmd;
		logic [BYTE_W-1:0] data;
	} lcdc_byte_s;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b01,
		ENG_CHAR = 2'b10
	} lcdc_eng_e;
endpackage : lcdc_pkg
`default_nettype wire

// ==== verilog/lcdc_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcdc_core
	import lcdc_pkg::*;
#(
	parameter int                      BUF_DEPTH    = 2,
	parameter int                      ROW_BASE_CYC = 64,
	parameter logic [CHAR_CODES*CG_BITS-1:0] CHAR_ROM = '0,
	parameter logic [7:0]              OP_LDP       = 8'h80,
	parameter logic [7:0]              MASK_LDP     = 8'h80,
	parameter logic [7:0]              OP_MODE      = 8'h40,
	parameter logic [7:0]              MASK_MODE    = 8'hE0,
	parameter logic [7:0]              OP_MMUX      = 8'h20,
	parameter logic [7:0]              MASK_MMUX    = 8'hE0,
	parameter logic [7:0]              OP_FFREQ     = 8'h10,
	parameter logic [7:0]              MASK_FFREQ   = 8'hF8,
	parameter logic [7:0]              OP_BIT_SET_CMD      = 8'h08,
	parameter logic [7:0]              OP_BCLR      = 8'h00,
	parameter logic [7:0]              MASK_BIT     = 8'hF8,
	parameter logic [7:0]              OP_CURS_WR   = 8'h1C,
	parameter logic [7:0]              OP_CURS_CLR  = 8'h1D
)(
	input  wire logic                mclk_i,
	input  wire logic                srst_i,
	input  wire logic                cs_n_i,
	input  wire logic                nibble_strobe_n_i,
	input  wire logic                cmd_data_i,
	input  wire logic [NIB_W-1:0]    data_nibble_lines_i,
	input  wire logic                sync_i,
	output logic [NIB_W-1:0]         data_nibble_lines_o,
	output logic [NIB_W-1:0]         data_nibble_lines_oe_o,
	output logic                     busy_n_o,
	output logic                     busy_oe_o,
	output logic                     sync_o,
	output logic                     sync_oe_o,
	output logic [NUM_ROWS-1:0]      row_o,
	output logic [NUM_COLS-1:0]      col_o,
	output logic                     frame_phase_o,
	output logic                     parallel_mode_o,
	output logic                     read_mode_o
);
	////////////////////////////////////////////////////////////////////////////
	localparam int BUF_AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int BUF_CW = $clog2(BUF_DEPTH + 1);

	logic [IN_W-1:0]       in_s1_q;
	logic [IN_W-1:0]       in_s2_q;
	logic                  stb_s3_q;
	logic                  sync_s3_q;
	logic                  rst_seen_q;
	logic                  par_q;
	logic [2:0]            cnt_q;
	logic [BYTE_W-1:0]     rx_q;
	logic [BYTE_W-1:0]     rx_d;
	logic [BYTE_W-1:0]     out_q;
	logic [NIB_W-1:0]      nib_q;
	logic                  pend_q;
	lcdc_byte_s            pend_byte_q;
	lcdc_byte_s            buf_q [BUF_DEPTH];
	logic [BUF_AW-1:0]     wr_ptr_q;
	logic [BUF_AW-1:0]     rd_ptr_q;
	logic [BUF_CW-1:0]     buf_cnt_q;
	lcdc_eng_e             eng_q;
	logic [2:0]            mode_q;
	logic [1:0]            dir_q;
	logic                  bank_q;
	logic [ADDR_W-1:0]     ptr_q;
	logic [2:0]            char_col_q;
	logic [7:0]            cg_idx_q;
	logic                  cg_ok_q;
	logic [2:0]            layout_q;
	logic                  disp_bank_q;
	logic                  sync_out_q;
	logic [3:0]            ffreq_q;
	logic [BYTE_W-1:0]     mem_q [2][BANK_WORDS];
	logic [15:0]           tick_q;
	logic [3:0]            row_q;
	logic                  sync_q;
	logic                  phase_q;
	logic [NUM_ROWS-1:0]   row_out_q;
	logic [NUM_COLS-1:0]   col_q;

	logic cs_act;
	logic stb_rise;
	logic stb_fall;
	logic sync_fall;
	logic byte_done;
	logic push_valid;
	logic buf_ready;
	lcdc_byte_s push_byte;
	lcdc_byte_s head;
	logic pop;
	logic is_char;
	logic is_ldp, is_mode, is_mmux, is_ffreq, is_bit_set_cmd, is_bclr, is_cwr, is_cclr;
	logic [ADDR_W-1:0] dir_step;
	logic [ADDR_W-1:0] chr_step;
	logic [BYTE_W-1:0] cur_word;
	logic [BYTE_W-1:0] char_old;
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [BYTE_W-1:0] mem_wd;
	logic [ADDR_W-1:0] char_wa;
	logic [CHAR_ROWS-1:0] glyph_col;
	logic              div16;
	logic [3:0]        row_last;
	logic [15:0]       row_limit;

	function automatic logic [BYTE_W-1:0] word_at(input logic b, input logic [ADDR_W-1:0] a);
		word_at = (a <= ADDR_LAST) ? mem_q[b][a] : '0;
	endfunction : word_at

	function automatic logic [ADDR_W-1:0] step_of(input logic [1:0] d);
		step_of = (d == DIR_UP) ? STEP_PLUS1 : (d == DIR_DOWN) ? STEP_MIN1 : '0;
	endfunction : step_of

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	always_ff @(posedge mclk_i)
	begin
		in_s1_q   <= {data_nibble_lines_i, sync_i, cmd_data_i, nibble_strobe_n_i, cs_n_i};
		in_s2_q   <= in_s1_q;
		stb_s3_q  <= in_s2_q[IN_STB];
		sync_s3_q <= in_s2_q[IN_SYNC];
	end

	assign cs_act    = ~in_s2_q[IN_CS];
	assign stb_rise  = in_s2_q[IN_STB] & ~stb_s3_q;
	assign stb_fall  = ~in_s2_q[IN_STB] & stb_s3_q;
	assign sync_fall = ~in_s2_q[IN_SYNC] & sync_s3_q;

	// interface form caught at the first cycle after reset
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			rst_seen_q <= 1'b1;
			par_q      <= 1'b0;
		end
		else if (rst_seen_q)
		begin
			rst_seen_q <= 1'b0;
			par_q      <= in_s2_q[IN_D+1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte assembly
	always_comb
	begin
		if (par_q)
			rx_d = (cnt_q == 3'h0) ? {in_s2_q[IN_D +: NIB_W], rx_q[3:0]}
			                       : {rx_q[7:4], in_s2_q[IN_D +: NIB_W]};
		else
			rx_d = {rx_q[6:0], in_s2_q[IN_D]};
	end

	assign byte_done = cs_act & stb_rise & (cnt_q == (par_q ? PAR_LAST : SER_LAST));

	always_ff @(posedge mclk_i)
	begin
		if (srst_i || !cs_act)
			cnt_q <= '0;
		else if (stb_rise)
			cnt_q <= byte_done ? 3'h0 : cnt_q + 3'h1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			rx_q <= '0;
		else if (cs_act && stb_rise)
			rx_q <= rx_d;
	end

	// read output, driven on falling edges
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			nib_q <= '0;
		else if (cs_act && stb_fall && mode_q == MODE_READ)
		begin
			if (par_q)
				nib_q <= (cnt_q == 3'h0) ? out_q[7:4] : out_q[3:0];
			else
				nib_q <= {out_q[3'h7 - cnt_q], 3'h0};
		end
	end

	assign data_nibble_lines_o    = nib_q;
	assign data_nibble_lines_oe_o = (cs_act && mode_q == MODE_READ) ?
	                                (par_q ? 4'hF : 4'h8) : 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// two-entry buffer between interface and engine
	assign buf_ready  = (buf_cnt_q != BUF_CW'(BUF_DEPTH));
	assign push_valid = pend_q | byte_done;
	assign push_byte  = pend_q ? pend_byte_q : lcdc_byte_s'{cmd: in_s2_q[IN_CD], data: rx_d};

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			pend_q      <= 1'b0;
			pend_byte_q <= '0;
		end
		else if (pend_q)
			pend_q <= ~buf_ready;
		else if (byte_done && !buf_ready)
		begin
			pend_q      <= 1'b1;
			pend_byte_q <= push_byte;
		end
	end

	assign head = buf_q[rd_ptr_q];
	assign pop  = (eng_q == ENG_IDLE) && (buf_cnt_q != '0);

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			buf_cnt_q <= '0;
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_q[i] <= '0;
		end
		else
		begin
			if (push_valid && buf_ready)
			begin
				buf_q[wr_ptr_q] <= push_byte;
				wr_ptr_q <= (int'(wr_ptr_q) == BUF_DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop)
				rd_ptr_q <= (int'(rd_ptr_q) == BUF_DEPTH - 1) ? '0 : rd_ptr_q + 1'b1;
			buf_cnt_q <= buf_cnt_q + BUF_CW'(push_valid && buf_ready) - BUF_CW'(pop);
		end
	end

	assign busy_n_o  = ~(pend_q | (buf_cnt_q != '0) | (eng_q != ENG_IDLE));
	assign busy_oe_o = cs_act;

	////////////////////////////////////////////////////////////////////////////
	// command decode
	assign is_ldp   = head.cmd && ((head.data & MASK_LDP) == OP_LDP);
	assign is_mode  = head.cmd && ((head.data & MASK_MODE) == OP_MODE);
	assign is_mmux  = head.cmd && ((head.data & MASK_MMUX) == OP_MMUX);
	assign is_ffreq = head.cmd && ((head.data & MASK_FFREQ) == OP_FFREQ);
	assign is_bit_set_cmd  = head.cmd && ((head.data & MASK_BIT) == OP_BIT_SET_CMD);
	assign is_bclr  = head.cmd && ((head.data & MASK_BIT) == OP_BCLR);
	assign is_cwr   = head.cmd && (head.data == OP_CURS_WR);
	assign is_cclr  = head.cmd && (head.data == OP_CURS_CLR);

	assign is_char  = (mode_q == MODE_CHAR_A) || (mode_q == MODE_CHAR_B);
	assign dir_step = step_of(dir_q);
	assign chr_step = (mode_q == MODE_CHAR_A) ? STEP_MIN5 : STEP_PLUS5;
	assign char_wa  = ptr_q + {3'h0, char_col_q};
	assign glyph_col = cg_ok_q ?
	    CHAR_ROM[int'(cg_idx_q) * CG_BITS + int'(char_col_q) * CHAR_ROWS +: CHAR_ROWS] : '0;

	// a process, so every memory write re-evaluates these reads
	always_comb
	begin
		cur_word = word_at(bank_q, ptr_q);
		char_old = word_at(bank_q, char_wa);
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			mode_q      <= MODE_RST;
			dir_q       <= DIR_RST;
			layout_q    <= LAYOUT_RST;
			disp_bank_q <= 1'b0;
			sync_out_q  <= 1'b0;
			ffreq_q     <= FFREQ_RST;
		end
		else if (pop && is_mode)
		begin
			mode_q <= head.data[2:0];
			dir_q  <= head.data[4:3];
		end
		else if (pop && is_mmux)
		begin
			layout_q    <= head.data[2:0];
			disp_bank_q <= head.data[3];
			sync_out_q  <= head.data[4];
		end
		else if (pop && is_ffreq)
			ffreq_q <= {1'b0, head.data[2:0]};
	end

	////////////////////////////////////////////////////////////////////////////
	// engine and pointer
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			eng_q      <= ENG_IDLE;
			char_col_q <= '0;
			cg_idx_q   <= '0;
			cg_ok_q    <= 1'b0;
		end
		else
		begin
			unique case (eng_q)
				ENG_IDLE:
					if (pop && !head.cmd && is_char)
					begin
						eng_q      <= ENG_CHAR;
						char_col_q <= '0;
						cg_ok_q    <= (head.data >= CG_SET1_LO && head.data <= CG_SET1_HI) ||
						              (head.data >= CG_SET2_LO && head.data <= CG_SET2_HI);
						cg_idx_q   <= (head.data >= CG_SET2_LO) ? head.data - CG_SET2_LO + CG_SET2_AT
						                                        : head.data - CG_SET1_LO;
					end
				ENG_CHAR:
					if (char_col_q == CHAR_LAST)
						eng_q <= ENG_IDLE;
					else
						char_col_q <= char_col_q + 3'h1;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			bank_q <= 1'b0;
			ptr_q  <= PTR_RST;
		end
		else if (pop && is_ldp)
		begin
			bank_q <= head.data[ADDR_W];
			ptr_q  <= head.data[ADDR_W-1:0];
		end
		else if (pop && is_mode && head.data[2:0] == MODE_READ)
			ptr_q <= ptr_q + step_of(head.data[4:3]);
		else if (pop && (is_bit_set_cmd || is_bclr || (!head.cmd && !is_char)))
			ptr_q <= ptr_q + dir_step;
		else if (pop && (is_cwr || is_cclr))
			ptr_q <= ptr_q + (is_char ? chr_step : dir_step);
		else if (eng_q == ENG_CHAR && char_col_q == CHAR_LAST)
			ptr_q <= ptr_q + chr_step;
	end

	// read register: preload on entering read mode, refetch after each data byte
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			out_q <= '0;
		else if (pop && ((is_mode && head.data[2:0] == MODE_READ) ||
		                 (!head.cmd && mode_q == MODE_READ)))
			out_q <= cur_word;
	end

	////////////////////////////////////////////////////////////////////////////
	// display memory write port
	always_comb
	begin
		mem_we = 1'b0;
		mem_wa = ptr_q;
		mem_wd = cur_word;
		if (eng_q == ENG_CHAR)
		begin
			mem_wa = char_wa;
			mem_we = (char_wa <= ADDR_LAST);
			mem_wd = {char_old[CURSOR_BIT], glyph_col};
		end
		else if (pop)
		begin
			mem_we = (ptr_q <= ADDR_LAST);
			if (!head.cmd && mode_q == MODE_WRITE)
				mem_wd = head.data;
			else if (!head.cmd && mode_q == MODE_AND)
				mem_wd = head.data & cur_word;
			else if (!head.cmd && mode_q == MODE_OR)
				mem_wd = head.data | cur_word;
			else if (is_bit_set_cmd)
				mem_wd = cur_word | (8'h01 << head.data[2:0]);
			else if (is_bclr)
				mem_wd = cur_word & ~(8'h01 << head.data[2:0]);
			else if (is_cwr)
				mem_wd = cur_word | 8'h80;
			else if (is_cclr)
				mem_wd = cur_word & 8'h7F;
			else
				mem_we = 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			for (int b = 0; b < 2; b++)
				for (int w = 0; w < BANK_WORDS; w++)
					mem_q[b][w] <= '0;
		end
		else if (mem_we)
			mem_q[bank_q][mem_wa] <= mem_wd;
	end

	////////////////////////////////////////////////////////////////////////////
	// frame timing and refresh
	assign div16     = layout_q[2];
	assign row_last  = div16 ? 4'hF : 4'h7;
	assign row_limit = 16'(ROW_BASE_CYC * (int'(ffreq_q) + 1));

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			tick_q  <= '0;
			row_q   <= '0;
			sync_q  <= 1'b0;
			phase_q <= 1'b0;
		end
		else if (!sync_out_q && sync_fall)
		begin
			tick_q  <= '0;
			row_q   <= '0;
			sync_q  <= 1'b0;
			phase_q <= ~phase_q;
		end
		else
		begin
			sync_q <= sync_out_q && (row_q == row_last);
			if (tick_q == row_limit - 16'h1)
			begin
				tick_q <= '0;
				if (row_q >= row_last)
				begin
					row_q   <= '0;
					phase_q <= ~phase_q;
				end
				else
					row_q <= row_q + 4'h1;
			end
			else
				tick_q <= tick_q + 16'h1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			row_out_q <= '0;
			col_q     <= '0;
		end
		else
		begin
			if (!div16)
				row_out_q <= 16'h0001 << row_q[2:0];
			else if (layout_q == LAYOUT_16_SINGLE)
				row_out_q <= 16'h0001 << row_q;
			else if (layout_q == LAYOUT_16_HIGH)
				row_out_q <= (16'h0001 << row_q) & 16'hFF00;
			else
				row_out_q <= (16'h0001 << row_q) & 16'h00FF;
			for (int m = 0; m < NUM_COLS; m++)
			begin
				if (!div16)
					col_q[m] <= mem_q[disp_bank_q][m][row_q[2:0]];
				else if (layout_q == LAYOUT_16_SINGLE && m >= COLS_16S)
					col_q[m] <= 1'b0;
				else
					col_q[m] <= mem_q[row_q[3]][m][row_q[2:0]];
			end
		end
	end

	assign sync_o          = sync_q;
	assign sync_oe_o       = sync_out_q;
	assign row_o           = row_out_q;
	assign col_o           = col_q;
	assign frame_phase_o   = phase_q;
	assign parallel_mode_o = par_q;
	assign read_mode_o     = (mode_q == MODE_READ);
endmodule : lcdc_core
`default_nettype wire

// ==== test/lcdc_core_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcdc_core_monitor
	import lcdc_pkg::*;
(
	input	wire logic			mclk_i,
	input	wire logic			srst_i,
	input	wire logic			cs_n_i,
	input	wire logic			nibble_strobe_n_i,
	input	wire logic [NIB_W-1:0]		data_nibble_lines_o,
	input	wire logic [NIB_W-1:0]		data_nibble_lines_oe_o,
	input	wire logic			busy_n_o,
	input	wire logic			busy_oe_o,
	input	wire logic			sync_o,
	input	wire logic			sync_oe_o,
	input	wire logic [NUM_ROWS-1:0]	row_o,
	input	wire logic			parallel_mode_o,
	input	wire logic			read_mode_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	logic [3:0]	since_rise_q;
	////////////////////////////////////////////////////////////
	// cycles since the last strobe rising edge
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || $rose(nibble_strobe_n_i))
			since_rise_q <= 4'h0;
		else if (since_rise_q != 4'hF)
			since_rise_q <= since_rise_q + 4'h1;
	end
	sequence busy_done_s;
		##[1:20] busy_n_o;
	endsequence
	////////////////////////////////////////////////////////////
	cs_hiz_a: assert property (cs_n_i [*4] |-> data_nibble_lines_oe_o == 4'h0 && !busy_oe_o)
		else $error("pins driven while deselected");
	out_read_a: assert property (data_nibble_lines_oe_o != 4'h0 |-> read_mode_o)
		else $error("output outside read mode");
	oe_form_a: assert property (data_nibble_lines_oe_o != 4'h0 |->
		data_nibble_lines_oe_o == (parallel_mode_o ? 4'hF : 4'h8))
		else $error("wrong output lanes");
	serial_pins_a: assert property (!parallel_mode_o |-> data_nibble_lines_o[2:0] == 3'h0)
		else $error("serial out on wrong lane");
	busy_cause_a: assert property ($fell(busy_n_o) |-> since_rise_q <= 4'h6)
		else $error("busy without completing edge");
	busy_end_a: assert property ($fell(busy_n_o) |-> busy_done_s)
		else $error("busy never released");
	form_hold_a: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> $stable(parallel_mode_o))
		else $error("interface form changed");
	read_clear_a: assert property ($fell(srst_i) |-> !read_mode_o)
		else $error("read mode after reset");
	row_hot_a: assert property ($onehot0(row_o))
		else $error("several rows active");
	sync_dir_a: assert property (sync_o |-> sync_oe_o)
		else $error("sync pulse while input");
endmodule : lcdc_core_monitor
bind lcdc_core lcdc_core_monitor i_lcdc_core_monitor (.mclk_i, .srst_i, .cs_n_i,
	.nibble_strobe_n_i, .data_nibble_lines_o, .data_nibble_lines_oe_o, .busy_n_o,
	.busy_oe_o, .sync_o, .sync_oe_o, .row_o, .parallel_mode_o, .read_mode_o);
`default_nettype wire

// ==== test/lcdc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcdc_host_model
	import lcdc_pkg::*;
(
	input	wire logic		mclk_i,
	input	wire logic		par_i,
	input	wire logic		busy_n_i,
	input	wire logic [NIB_W-1:0]	line_i,
	output	logic			cs_n_o,
	output	logic			stb_n_o,
	output	logic			cd_o,
	output	logic [NIB_W-1:0]	d_o,
	output	logic			tmo_o
);
	initial
	begin
		cs_n_o = 1'b1;
		stb_n_o = 1'b1;
		cd_o = 1'b0;
		d_o = 4'h0;
		tmo_o = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// one strobe period, lines inverted once released
	task automatic unit(input logic [NIB_W-1:0] v, output logic [NIB_W-1:0] r);
		@(negedge mclk_i);
		stb_n_o = 1'b0;
		d_o = v;
		repeat (4) @(negedge mclk_i);
		r = line_i;
		stb_n_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		d_o = ~v;
	endtask : unit
	task automatic xfer(input logic cd, input logic [7:0] b, output logic [7:0] r);
		logic [NIB_W-1:0]	g;
		int			n;
		cs_n_o = 1'b0;
		cd_o = cd;
		if (par_i)
		begin
			unit(b[7:4], g);
			r[7:4] = g;
			unit(b[3:0], g);
			r[3:0] = g;
		end
		else
			for (int i = 7; i >= 0; i--)
			begin
				unit({3'h0, b[i]}, g);
				r[i] = g[3];
			end
		n = 0;
		while (busy_n_i !== 1'b1 && n < 50)
		begin
			@(negedge mclk_i);
			n++;
		end
		if (n == 50)
			tmo_o = 1'b1;
	endtask : xfer
	// one strobe period (half a byte in parallel form, one bit in serial), then deselect
	task automatic part();
		logic [NIB_W-1:0]	g;
		cs_n_o = 1'b0;
		unit(4'h5, g);
		cs_n_o = 1'b1;
		repeat (6) @(negedge mclk_i);
	endtask : part
endmodule : lcdc_host_model
`default_nettype wire

// ==== test/lcdc_core_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcdc_core_tb_top;
	import lcdc_pkg::*;
	localparam logic [CHAR_CODES*CG_BITS-1:0] ROM = {175{32'h9E3779B9}};
	logic		mclk = 1'b0;
	logic		srst = 1'b1;
	logic		par = 1'b1;
	wire logic	cs_n, stb_n, cd, tmo, busy_n, busy_oe, pmode, rmode;
	wire logic [3:0]	dq, oe, d_h, line;
	wire logic [NUM_ROWS-1:0]	rows;
	wire logic [NUM_COLS-1:0]	cols;
	wire logic		fph;
	integer		seed;
	int		miscompares = 0;
	int		samples_checked = 0;
	logic [7:0]	ex [64];
	logic		vl [64];
	assign line = (oe & dq) | (~oe & d_h);
	always #25 mclk = ~mclk;
	lcdc_core #(
		.ROW_BASE_CYC	(2),
		.CHAR_ROM	(ROM)
	) i_lcdc_core (
		.mclk_i			(mclk),
		.srst_i			(srst),
		.cs_n_i			(cs_n),
		.nibble_strobe_n_i	(stb_n),
		.cmd_data_i		(cd),
		.data_nibble_lines_i	(line),
		.sync_i			(1'b0),
		.data_nibble_lines_o	(dq),
		.data_nibble_lines_oe_o	(oe),
		.busy_n_o		(busy_n),
		.busy_oe_o		(busy_oe),
		.sync_o			(),
		.sync_oe_o		(),
		.row_o			(rows),
		.col_o			(cols),
		.frame_phase_o		(fph),
		.parallel_mode_o	(pmode),
		.read_mode_o		(rmode)
	);
	lcdc_host_model i_host (
		.mclk_i		(mclk),
		.par_i		(par),
		.busy_n_i	(busy_oe & busy_n),
		.line_i		(line),
		.cs_n_o		(cs_n),
		.stb_n_o	(stb_n),
		.cd_o		(cd),
		.d_o		(d_h),
		.tmo_o		(tmo)
	);
	////////////////////////////////////////////////////////////
	function automatic logic [6:0] gcol(input logic [7:0] c, input int k);
		int	x;
		x = (c < CG_SET2_LO) ? c - CG_SET1_LO : c - CG_SET2_LO + 96;
		return ROM[x * CG_BITS + k * CHAR_ROWS +: 7];
	endfunction : gcol
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic put(input int a, input logic [7:0] v);
		ex[a] = v;
		vl[a] = 1'b1;
	endtask : put
	task automatic cmd(input logic [7:0] b);
		logic [7:0]	r;
		i_host.xfer(1'b1, b, r);
	endtask : cmd
	task automatic wr(input logic [7:0] b);
		logic [7:0]	r;
		i_host.xfer(1'b0, b, r);
	endtask : wr
	task automatic rst_to(input logic p);
		@(negedge mclk);
		par = p;
		i_host.d_o = {2'h0, p, 1'b0};
		srst = 1'b1;
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		repeat (6) @(negedge mclk);
		chk({5'h00, pmode, rmode, busy_n}, {5'h00, p, 2'h1});
	endtask : rst_to
	////////////////////////////////////////////////////////////
	task automatic run(input logic [7:0] c1, input logic [7:0] c2);
		logic [7:0]	r, v;
		logic		b;
		logic [2:0]	n;
		logic [5:0]	p;
		b = 1'($random(seed));
		n = 3'($random(seed));
		v = 8'($random(seed));
		vl = '{default: 1'b0};
		i_host.part();
		cmd(8'h37);
		cmd({1'b1, b, 6'h14});
		wr(8'h00);
		put(20, 8'h00);
		cmd({1'b1, b, 6'h00});
		cmd(8'h48);
		for (int i = 0; i < 20; i++)
		begin
			r = (i >= 10) ? 8'hFF : 8'($random(seed));
			wr(r);
			put(i, r);
		end
		cmd({1'b1, b, 6'h00});
		cmd(8'h49);
		wr(v);
		put(0, ex[0] & v);
		cmd(8'h4A);
		wr(v);
		put(1, ex[1] | v);
		cmd({1'b1, b, 6'h02});
		cmd(8'h40);
		cmd({5'h01, n});
		cmd({5'h00, n + 3'h1});
		put(2, (ex[2] | (8'h01 << n)) & ~(8'h01 << (n + 3'h1)));
		cmd({1'b1, b, 6'h31});
		cmd(8'h48);
		wr(v);
		put(49, v);
		wr(~v);
		cmd({1'b1, b, 6'h00});
		cmd(8'h50);
		wr(~v);
		put(0, ~v);
		wr(~v);
		cmd({1'b1, b, 6'h0A});
		cmd(8'h45);
		wr(c1);
		wr(c2);
		for (int k = 0; k < 5; k++)
		begin
			put(10 + k, {1'b1, gcol(c1, k)});
			put(15 + k, {1'b1, gcol(c2, k)});
		end
		cmd(8'h1C);
		put(20, 8'h80);
		cmd({1'b1, b, 6'h14});
		cmd(8'h53);
		p = 6'h14;
		for (int k = 0; k < 36; k++)
		begin
			i_host.xfer(1'b0, 8'h00, r);
			if (vl[p])
				chk(r, ex[p]);
			p = p - 6'h01;
		end
		scan(b);
	endtask : run
	// one full 16-row frame of refresh against the expected image
	task automatic scan(input logic b);
		logic			ph;
		int			r;
		logic [NUM_COLS-1:0]	e;
		ph = fph;
		for (int t = 0; t < 2 * NUM_ROWS; t++)
		begin
			@(negedge mclk);
			r = 0;
			for (int i = 0; i < NUM_ROWS; i++)
				if (rows[i])
					r = i;
			e = '0;
			for (int m = 0; m < COLS_16S; m++)
				if (vl[m] && ((r >= 8) == b))
					e[m] = ex[m][r % 8];
			samples_checked++;
			if (cols !== e || rows !== (16'h0001 << r))
			begin
				miscompares++;
				$display("[ERR] %0t row %0d cols %h exp %h", $time, r, cols, e);
			end
		end
		chk({7'h00, fph}, {7'h00, ~ph});
	endtask : scan
	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial
	begin
		seed = 32'hA3D05C51;
		rst_to(1'b1);
		run(8'h20, 8'hDF);
		rst_to(1'b0);
		run(8'h7F, 8'hA0);
		if (tmo !== 1'b0)
			miscompares++;
		finish_test();
	end
	initial
	begin
		#4000000;
		miscompares++;
		finish_test();
	end
endmodule : lcdc_core_tb_top
`default_nettype wire
